// ### bthw_pkg.sv
// Shared constants and types for the wake handshake and power control block.
package bthw_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned IO_SETTLE_NS    = 2000;
   localparam int unsigned IO_SETTLE_CYC   = (IO_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned INIT_CYC        = 64;
   localparam int unsigned CLKREQ_DLY_CYC  = 8;
   localparam int unsigned SLEEP_IDLE_CYC  = 32;
   localparam int unsigned CNT_W           = 16;
   localparam logic [1:0]  MODE_ACTIVE     = 2'h0;
   localparam logic [1:0]  MODE_SNIFF      = 2'h1;
   localparam logic [1:0]  MODE_HOLD       = 2'h2;
   localparam logic [1:0]  MODE_PARK       = 2'h3;
   localparam logic [3:0]  RF_ALL_DOWN     = 4'hF;

   typedef enum logic [5:0] {
      ST_RESET    = 6'h01,
      ST_SETTLE   = 6'h02,
      ST_INIT     = 6'h04,
      ST_AWAKE    = 6'h08,
      ST_SLEEP    = 6'h10,
      ST_SHUTDOWN = 6'h20
   } bthw_state_e;
endpackage : bthw_pkg

// ### bthw_sync.sv
// Three-stage input synchroniser with agreement filter on the last two stages.
`timescale 1ns/1ps
module bthw_sync
   import bthw_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
)(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic asyncIn,
   output logic      syncOut
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } bthw_sync_s;

   bthw_sync_s st;
   bthw_sync_s next_st;

   always_comb
   begin
      next_st    = st;
      next_st.s1 = asyncIn;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // The first stage feeds only the second; a change counts once stages two and three agree.
      if (st.s2 == st.s3)
      begin
         next_st.q = st.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, q: RESET_VAL};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign syncOut = st.q;
endmodule : bthw_sync

// ### bthw_timer.sv
// Loadable down-counter used for settle, init and low-power wake periods.
`timescale 1ns/1ps
module bthw_timer
   import bthw_pkg::*;
#(
   parameter int unsigned WIDTH = CNT_W
)(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadVal,
   output logic                  expired
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             done;
   } bthw_timer_s;

   bthw_timer_s st;
   bthw_timer_s next_st;

   always_comb
   begin
      next_st = st;
      if (load)
      begin
         next_st.cnt  = loadVal;
         next_st.done = 1'b0;
      end
      else if (st.cnt != '0)
      begin
         next_st.cnt = st.cnt - 1'b1;
      end
      else
      begin
         next_st.done = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '{cnt: '0, done: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign expired = st.done & ~load;
endmodule : bthw_timer

// ### bthw_power_ctrl.sv
// Wake handshake, startup signalling and RF power-down control for the baseband core.
//
// Overview of operation
// - Wake handshake only with UART and enabled
// - Wake request asserted keeps device awake
// - Sleep only after criteria met, request off
// - Assert host wake when device needs host
// - Wake signal polarities selectable by software
// - Ready low only after init and clear
// - Clock request rises after power enable
// - Power actions from software or packets
// - Separate TX, RX, PLL, PA power-downs
// - RF sections enabled only while needed
// - Low-power modes use slow clock, timed wake
// - Shutdown tristates outputs, gates inputs
// - Reset held while power enable low
`timescale 1ns/1ps
module bthw_power_ctrl
   import bthw_pkg::*;
#(
   parameter int unsigned SETTLE_CYC = IO_SETTLE_CYC,
   parameter int unsigned INIT_CYCLES = INIT_CYC,
   parameter int unsigned CLKREQ_CYC = CLKREQ_DLY_CYC,
   parameter int unsigned IDLE_CYC = SLEEP_IDLE_CYC,
   parameter int unsigned LP_WAKE_CYC = 4000
)(
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             radioPowerEnable,
   input  wire logic             deviceWakeRequest,
   input  wire logic             linkClearInN,
   input  wire logic             uartTransport,
   input  wire logic             wakeHandshakeEn,
   input  wire logic             devWakeActiveHigh,
   input  wire logic             hostWakeActiveHigh,
   input  wire logic             extRefClock,
   input  wire logic             refClockSettled,
   input  wire logic             swShutdown,
   input  wire logic             swSleepAllowed,
   input  wire logic [1:0]       swLowPowerMode,
   input  wire logic             pktLowPowerReq,
   input  wire logic [1:0]       pktLowPowerMode,
   input  wire logic             hostAttnNeeded,
   input  wire logic             pktTxActive,
   input  wire logic             pktRxActive,
   input  wire logic             pktPaActive,
   output logic                  hostWakeRequest,
   output logic                  hostWakeOe,
   output logic                  linkReadyOutN,
   output logic                  linkReadyOe,
   output logic                  refclkRequest,
   output logic                  refclkRequestOe,
   output logic                  txPowerDown,
   output logic                  rxPowerDown,
   output logic                  pllPowerDown,
   output logic                  paPowerDown,
   output logic                  lowPowerClkSel,
   output logic                  coreAwake,
   output logic [1:0]            lowPowerMode
);
   typedef struct packed {
      bthw_state_e state;
      logic        porHeld;
      logic        hostWake;
      logic        readyN;
      logic        oe;
      logic        clkReq;
      logic [CNT_W-1:0] clkReqCnt;
      logic [CNT_W-1:0] idleCnt;
      logic [3:0]  rfDown;
      logic        lpClk;
      logic        awake;
      logic [1:0]  mode;
      logic        timerLoad;
      logic [CNT_W-1:0] timerVal;
   } bthw_ctrl_s;

   bthw_ctrl_s st;
   bthw_ctrl_s next_st;

   logic devWakeSync;
   logic clearSync;
   logic powerSync;
   logic timerExpired;

   // Every pin from the host side is filtered before the state machine sees it.
   bthw_sync #(.RESET_VAL(1'b0)) uDevWake
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .asyncIn (deviceWakeRequest),
      .syncOut (devWakeSync)
   );

   bthw_sync #(.RESET_VAL(1'b1)) uClear
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .asyncIn (linkClearInN),
      .syncOut (clearSync)
   );

   bthw_sync #(.RESET_VAL(1'b0)) uPower
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .asyncIn (radioPowerEnable),
      .syncOut (powerSync)
   );

   bthw_timer #(.WIDTH(CNT_W)) uTimer
   (
      .clk     (clk),
      .rst_b   (rst_b),
      .load    (st.timerLoad),
      .loadVal (st.timerVal),
      .expired (timerExpired)
   );

   function automatic logic wake_asserted(input logic level, input logic activeHigh);
      wake_asserted = activeHigh ? level : ~level;
   endfunction : wake_asserted

   logic handshakeOn;
   logic wakeReq;
   logic lowPowerReq;
   logic [1:0] reqMode;

   always_comb
   begin
      handshakeOn = uartTransport & wakeHandshakeEn;
      wakeReq     = handshakeOn & wake_asserted(devWakeSync, devWakeActiveHigh);
      lowPowerReq = swSleepAllowed | pktLowPowerReq;
      reqMode     = pktLowPowerReq ? pktLowPowerMode : swLowPowerMode;
   end

   always_comb
   begin
      next_st           = st;
      next_st.timerLoad = 1'b0;
      next_st.timerVal  = st.timerVal;

      // Clock request follows power enable after a fixed delay, only with a host clock.
      if (!powerSync || !extRefClock)
      begin
         next_st.clkReqCnt = '0;
         next_st.clkReq    = 1'b0;
      end
      else if (st.clkReqCnt < CNT_W'(CLKREQ_CYC))
      begin
         next_st.clkReqCnt = st.clkReqCnt + 1'b1;
      end
      else
      begin
         next_st.clkReq = 1'b1;
      end

      unique case (st.state)
         ST_RESET:
         begin
            next_st.readyN = 1'b1;
            if (powerSync && refClockSettled)
            begin
               next_st.porHeld   = 1'b0;
               next_st.state     = ST_SETTLE;
               next_st.timerLoad = 1'b1;
               next_st.timerVal  = CNT_W'(SETTLE_CYC);
            end
         end
         ST_SETTLE:
         begin
            if (timerExpired)
            begin
               next_st.oe        = 1'b1;
               next_st.state     = ST_INIT;
               next_st.timerLoad = 1'b1;
               next_st.timerVal  = CNT_W'(INIT_CYCLES);
            end
         end
         ST_INIT:
         begin
            if (timerExpired)
            begin
               next_st.state = ST_AWAKE;
               next_st.awake = 1'b1;
            end
         end
         ST_AWAKE:
         begin
            next_st.readyN = clearSync;
            if (wakeReq || !lowPowerReq || reqMode == MODE_ACTIVE)
            begin
               next_st.idleCnt = '0;
            end
            else if (st.idleCnt < CNT_W'(IDLE_CYC))
            begin
               next_st.idleCnt = st.idleCnt + 1'b1;
            end
            else
            begin
               next_st.state     = ST_SLEEP;
               next_st.mode      = reqMode;
               next_st.lpClk     = 1'b1;
               next_st.awake     = 1'b0;
               next_st.readyN    = 1'b1;
               next_st.timerLoad = 1'b1;
               next_st.timerVal  = CNT_W'(LP_WAKE_CYC);
            end
         end
         ST_SLEEP:
         begin
            if (wakeReq || timerExpired)
            begin
               next_st.state   = ST_AWAKE;
               next_st.mode    = MODE_ACTIVE;
               next_st.lpClk   = 1'b0;
               next_st.awake   = 1'b1;
               next_st.idleCnt = '0;
            end
         end
         ST_SHUTDOWN:
         begin
            if (!swShutdown)
            begin
               next_st.state   = ST_RESET;
               next_st.porHeld = 1'b1;
            end
         end
      endcase

      // Host attention is raised when the core has something for the host, the handshake is on and the block is not shut down.
      next_st.hostWake = handshakeOn & hostAttnNeeded & (st.state != ST_SHUTDOWN);

      if (swShutdown && st.state != ST_SHUTDOWN)
      begin
         next_st.state   = ST_SHUTDOWN;
         next_st.oe      = 1'b0;
         next_st.awake   = 1'b0;
         next_st.lpClk   = 1'b0;
         next_st.mode    = MODE_ACTIVE;
         next_st.readyN  = 1'b1;
      end

      // Losing power enable forces the whole block back into reset, whatever the state.
      if (!powerSync)
      begin
         next_st.state   = ST_RESET;
         next_st.porHeld = 1'b1;
         next_st.oe      = 1'b0;
         next_st.awake   = 1'b0;
         next_st.lpClk   = 1'b0;
         next_st.mode    = MODE_ACTIVE;
         next_st.readyN  = 1'b1;
         next_st.idleCnt = '0;
      end

      // Judged on the next state, so the sections drop in the same cycle as the awake flag.
      if (next_st.state == ST_AWAKE)
      begin
         next_st.rfDown[0] = ~pktTxActive;
         next_st.rfDown[1] = ~pktRxActive;
         next_st.rfDown[2] = ~(pktTxActive | pktRxActive);
         next_st.rfDown[3] = ~(pktTxActive & pktPaActive);
      end
      else
      begin
         next_st.rfDown = RF_ALL_DOWN;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st.state     <= ST_RESET;
         st.porHeld   <= 1'b1;
         st.hostWake  <= 1'b0;
         st.readyN    <= 1'b1;
         st.oe        <= 1'b0;
         st.clkReq    <= 1'b0;
         st.clkReqCnt <= '0;
         st.idleCnt   <= '0;
         st.rfDown    <= RF_ALL_DOWN;
         st.lpClk     <= 1'b0;
         st.awake     <= 1'b0;
         st.mode      <= MODE_ACTIVE;
         st.timerLoad <= 1'b0;
         st.timerVal  <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Polarity is applied at the pin so a polarity change never glitches the state machine.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hostWakeRequest <= 1'b0;
         hostWakeOe      <= 1'b0;
         linkReadyOutN   <= 1'b1;
         linkReadyOe     <= 1'b0;
         refclkRequest   <= 1'b0;
         refclkRequestOe <= 1'b0;
         txPowerDown     <= 1'b1;
         rxPowerDown     <= 1'b1;
         pllPowerDown    <= 1'b1;
         paPowerDown     <= 1'b1;
         lowPowerClkSel  <= 1'b0;
         coreAwake       <= 1'b0;
         lowPowerMode    <= MODE_ACTIVE;
      end
      else
      begin
         hostWakeRequest <= hostWakeActiveHigh ? st.hostWake : ~st.hostWake;
         hostWakeOe      <= st.oe & handshakeOn;
         linkReadyOutN   <= st.readyN;
         linkReadyOe     <= st.oe;
         refclkRequest   <= st.clkReq;
         refclkRequestOe <= extRefClock & (st.state != ST_SHUTDOWN);
         txPowerDown     <= st.rfDown[0];
         rxPowerDown     <= st.rfDown[1];
         pllPowerDown    <= st.rfDown[2];
         paPowerDown     <= st.rfDown[3];
         lowPowerClkSel  <= st.lpClk;
         coreAwake       <= st.awake;
         lowPowerMode    <= st.mode;
      end
   end
endmodule : bthw_power_ctrl

// ### bthw_power_ctrl_chk.sv
// Assertion checker for the wake handshake and power control block.
`timescale 1ns/1ps
module bthw_power_ctrl_chk
   import bthw_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       radioPowerEnable,
   input wire logic       deviceWakeRequest,
   input wire logic       linkClearInN,
   input wire logic       uartTransport,
   input wire logic       wakeHandshakeEn,
   input wire logic       devWakeActiveHigh,
   input wire logic       hostWakeActiveHigh,
   input wire logic       extRefClock,
   input wire logic       swShutdown,
   input wire logic       hostAttnNeeded,
   input wire logic       hostWakeRequest,
   input wire logic       hostWakeOe,
   input wire logic       linkReadyOutN,
   input wire logic       linkReadyOe,
   input wire logic       refclkRequest,
   input wire logic       refclkRequestOe,
   input wire logic       txPowerDown,
   input wire logic       rxPowerDown,
   input wire logic       pllPowerDown,
   input wire logic       paPowerDown,
   input wire logic       lowPowerClkSel,
   input wire logic       coreAwake,
   input wire logic [1:0] lowPowerMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence wakeHeld;
      (uartTransport && wakeHandshakeEn && radioPowerEnable && !swShutdown
       && deviceWakeRequest == devWakeActiveHigh)[*8];
   endsequence
   sequence attnHeld;
      (hostWakeOe && hostAttnNeeded && $stable(hostWakeActiveHigh))[*3];
   endsequence
   a_wake_keeps_awake: assert property (wakeHeld |-> !lowPowerClkSel)
      else $error("Device slept while wake request was held.");
   a_host_wake_pol: assert property (attnHeld |-> hostWakeRequest == hostWakeActiveHigh)
      else $error("Host wake level wrong.");
   a_refuse_wake: assert property (!(uartTransport && wakeHandshakeEn) [*2] |-> !hostWakeOe)
      else $error("Host wake driven while handshake disabled.");
   a_ready_follows: assert property ((coreAwake && !linkClearInN)[*7] |-> !linkReadyOutN)
      else $error("Ready not given to clear request.");
   a_ready_awake: assert property (!linkReadyOutN |-> coreAwake && linkReadyOe)
      else $error("Ready low before initialisation.");
   a_refclk_after_pwr: assert property ($rose(refclkRequest) |-> extRefClock && $past(radioPowerEnable, 8))
      else $error("Clock request rose too early.");
   a_rf_asleep: assert property (!coreAwake |-> txPowerDown && rxPowerDown && pllPowerDown && paPowerDown)
      else $error("RF section on while core not awake.");
   a_rf_path_deps: assert property ((!txPowerDown || !rxPowerDown) |-> !pllPowerDown && (paPowerDown || !txPowerDown))
      else $error("RF section dependencies broken.");
   a_lp_oscillator: assert property (lowPowerClkSel |-> !coreAwake && lowPowerMode != MODE_ACTIVE)
      else $error("Slow clock selected outside low-power mode.");
   a_shutdown_hiz: assert property (swShutdown [*4] |-> !hostWakeOe && !linkReadyOe && !refclkRequestOe)
      else $error("Output driven in shutdown.");
   a_pwr_holds_reset: assert property (!radioPowerEnable [*8] |-> !coreAwake && !linkReadyOe)
      else $error("Device active without power enable.");
endmodule : bthw_power_ctrl_chk

bind bthw_power_ctrl bthw_power_ctrl_chk chk (.*);

// ### bthw_host_model.sv
// Behavioural host processor on the far side of the wake and startup pins.
`timescale 1ns/1ps
module bthw_host_model
   import bthw_pkg::*;
#(
   parameter int unsigned HOST_SETTLE = 10
)(
   input  wire logic clk,
   input  wire logic hostReset_b,
   input  wire logic needDevice,
   input  wire logic wantClear,
   input  wire logic devWakeActiveHigh,
   input  wire logic hostWakeActiveHigh,
   input  wire logic hostWakeRequest,
   output logic      radioPowerEnable,
   output logic      deviceWakeRequest,
   output logic      linkClearInN,
   output logic      hostAwake
);
   int settle;
   initial
   begin
      radioPowerEnable = 1'b0;
      deviceWakeRequest = 1'b0;
      linkClearInN = 1'b1;
      hostAwake = 1'b1;
      settle = 0;
   end
   // Power enable waits for the host's own IOs, so a reset host never powers the radio.
   always @(posedge clk or negedge hostReset_b)
      if (!hostReset_b)
      begin
         settle <= 0;
         radioPowerEnable <= 1'b0;
      end
      else if (settle < HOST_SETTLE)
         settle <= settle + 1;
      else
         radioPowerEnable <= 1'b1;
   always @(posedge clk)
   begin
      deviceWakeRequest <= needDevice ? devWakeActiveHigh : !devWakeActiveHigh;
      linkClearInN <= !wantClear;
      hostAwake <= (hostWakeRequest == hostWakeActiveHigh) || needDevice;
   end
endmodule : bthw_host_model

// ### tb_bthw_power_ctrl.sv
// Self-checking bench for the wake handshake and power control block.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t mismatch line %0d", $time, `__LINE__); end end
`define WAIT(c) for (int k = 0; k < 400 && !(c); k++) @(posedge clk)
module tb_bthw_power_ctrl
   import bthw_pkg::*;
;
   logic clk, rst_b, radioPowerEnable, deviceWakeRequest, linkClearInN, uartTransport, wakeHandshakeEn;
   logic devWakeActiveHigh, hostWakeActiveHigh, extRefClock, refClockSettled, swShutdown, swSleepAllowed;
   logic pktLowPowerReq, hostAttnNeeded, pktTxActive, pktRxActive, pktPaActive, hostWakeRequest, hostWakeOe;
   logic linkReadyOutN, linkReadyOe, refclkRequest, refclkRequestOe, txPowerDown, rxPowerDown, pllPowerDown;
   logic paPowerDown, lowPowerClkSel, coreAwake, hostReset_b, needDevice, wantClear, hostAwake;
   logic [1:0] swLowPowerMode, pktLowPowerMode, lowPowerMode;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   bthw_power_ctrl #(.SETTLE_CYC(20), .INIT_CYCLES(4), .IDLE_CYC(4), .LP_WAKE_CYC(20)) DUT (.*);
   bthw_host_model host (.*);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task conclude;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // The whole run needs a few hundred cycles; this only cuts a hang short.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         conclude();
      end
   end
   task powerUp;
      hostReset_b <= 1'b1;
      `WAIT(refclkRequest);
      `CHK(refclkRequest, 1'b1)
      repeat (40) @(posedge clk);
      `CHK(linkReadyOe, 1'b0)
      refClockSettled <= 1'b1;
      `WAIT(coreAwake);
      repeat (10) @(posedge clk);
      `CHK({coreAwake, linkReadyOutN}, 2'h3)
      wantClear <= 1'b1;
      `WAIT(!linkReadyOutN);
      `CHK(linkReadyOutN, 1'b0)
   endtask : powerUp
   task rfPaths;
      for (int i = 0; i < 8; i++)
      begin
         {pktTxActive, pktRxActive, pktPaActive} <= 3'(i);
         repeat (4) @(posedge clk);
         `CHK({txPowerDown, rxPowerDown, pllPowerDown, paPowerDown}, {!i[2], !i[1], !(i[2] | i[1]), !(i[2] & i[0])})
      end
      {pktTxActive, pktRxActive, pktPaActive} <= 3'h0;
   endtask : rfPaths
   task hostWake;
      for (int i = 0; i < 4; i++)
      begin
         {hostWakeActiveHigh, hostAttnNeeded} <= 2'(i);
         repeat (4) @(posedge clk);
         `CHK(hostWakeRequest, i[0] ? i[1] : !i[1])
         `CHK(hostAwake, i[0])
      end
      {hostWakeActiveHigh, hostAttnNeeded} <= 2'h2;
   endtask : hostWake
   task sleepWake(input logic [1:0] mode, input logic usePkt);
      pktLowPowerReq <= usePkt;
      pktLowPowerMode <= usePkt ? mode : MODE_ACTIVE;
      swLowPowerMode <= usePkt ? MODE_ACTIVE : mode;
      repeat (4) @(posedge clk);
      `CHK(coreAwake, 1'b1)
      `WAIT(lowPowerClkSel);
      `CHK({lowPowerClkSel, coreAwake, lowPowerMode, linkReadyOutN, txPowerDown}, {2'h2, mode, 2'h3})
      pktLowPowerReq <= 1'b0;
      swLowPowerMode <= MODE_ACTIVE;
      `WAIT(coreAwake);
      `CHK(coreAwake, 1'b1)
   endtask : sleepWake
   task wakeHold;
      devWakeActiveHigh <= 1'b0;
      needDevice <= 1'b1;
      pktLowPowerReq <= 1'b1;
      pktLowPowerMode <= MODE_PARK;
      repeat (30) @(posedge clk);
      `CHK(lowPowerClkSel, 1'b0)
      needDevice <= 1'b0;
      `WAIT(lowPowerClkSel);
      `CHK(lowPowerClkSel, 1'b1)
      needDevice <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK(coreAwake, 1'b1)
      pktLowPowerReq <= 1'b0;
   endtask : wakeHold
   task refuseAndOff;
      needDevice <= 1'b0;
      swSleepAllowed <= 1'b0;
      swLowPowerMode <= MODE_SNIFF;
      extRefClock <= 1'b0;
      repeat (16) @(posedge clk);
      `CHK({refclkRequest, refclkRequestOe}, 2'h0)
      `CHK({lowPowerClkSel, coreAwake}, 2'h1)
      swSleepAllowed <= 1'b1;
      swLowPowerMode <= MODE_ACTIVE;
      extRefClock <= 1'b1;
      wakeHandshakeEn <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(hostWakeOe, 1'b0)
      wakeHandshakeEn <= 1'b1;
      uartTransport <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(hostWakeOe, 1'b0)
      uartTransport <= 1'b1;
      swShutdown <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK({hostWakeOe, linkReadyOe, refclkRequestOe}, 3'h0)
      swShutdown <= 1'b0;
      `WAIT(coreAwake);
      hostReset_b <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK({coreAwake, linkReadyOe}, 2'h0)
      hostReset_b <= 1'b1;
      `WAIT(coreAwake);
      `CHK(coreAwake, 1'b1)
   endtask : refuseAndOff
   initial
   begin
      {rst_b, hostReset_b, needDevice, wantClear, refClockSettled, swShutdown} = 6'h0;
      {uartTransport, wakeHandshakeEn, devWakeActiveHigh, hostWakeActiveHigh, extRefClock, swSleepAllowed} = 6'h3F;
      {pktLowPowerReq, hostAttnNeeded, pktTxActive, pktRxActive, pktPaActive} = 5'h0;
      {swLowPowerMode, pktLowPowerMode} = 4'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      powerUp();
      rfPaths();
      hostWake();
      for (int m = 1; m < 4; m++)
         sleepWake(2'(m), m[0]);
      wakeHold();
      refuseAndOff();
      conclude();
   end
endmodule : tb_bthw_power_ctrl
